// file: pkg/ltac_pkg.sv
// Package: register map, field positions and constants of the logger alarm/config bank
package ltac_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [9:0] ADDR_LOW_THRESH  = 10'h208;
  localparam logic [9:0] ADDR_HIGH_THRESH = 10'h209;
  localparam logic [9:0] ADDR_RESULT_LOW  = 10'h20C;
  localparam logic [9:0] ADDR_RESULT_HIGH = 10'h20D;
  localparam logic [9:0] ADDR_SENSOR_CTRL = 10'h210;
  localparam logic [9:0] ADDR_OSC_CTRL    = 10'h212;
  localparam logic [9:0] ADDR_MISSION     = 10'h213;
  localparam logic [9:0] ADDR_ALARM_STAT  = 10'h214;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_LOW_ALARM_EN   = 0;
  localparam int BIT_HIGH_ALARM_EN  = 1;
  localparam int BIT_OSC_EN         = 0;
  localparam int BIT_SECONDS_UNIT   = 1;
  localparam int BIT_LOGGING_EN     = 0;
  localparam int BIT_UNAVAIL_FUNC   = 1;
  localparam int BIT_LOG_FORMAT     = 2;
  localparam int BIT_DONT_CARE      = 3;
  localparam int BIT_START_ON_ALARM = 5;

  // Writable masks and forced-one patterns
  localparam logic [7:0] SENSOR_WR_MASK   = 8'h03;
  localparam logic [7:0] OSC_WR_MASK      = 8'h03;
  localparam logic [7:0] MISSION_WR_MASK  = 8'h2F;
  localparam logic [7:0] MISSION_ONES     = 8'hD0;
  localparam logic [7:0] ALARM_STAT_ONES  = 8'h70;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]  RESET_BYTE   = 8'h00;
  localparam logic [10:0] RESET_RESULT = 11'h000;

  // Offset between Celsius code and byte: code = 2*C + 82
  localparam int THRESH_OFFSET = 82;
  // First data-log address used by logging
  localparam logic [15:0] LOG_BASE_ADDR = 16'h1000;

  // Oscillator start-up delay from cleared-memory state, in clock cycles
  localparam int OSC_STARTUP_CYCLES = 1000;

  // Oscillator states
  typedef enum logic [2:0]
  {
    OSC_OFF   = 3'b001,
    OSC_START = 3'b010,
    OSC_RUN   = 3'b100
  } ltac_osc_state_type;

endpackage

// file: design/ltac_alarm_cmp.sv
// Threshold comparator on the upper byte of a conversion
`timescale 1ns/1ps

module ltac_alarm_cmp
(
  input  wire logic [7:0] high_byte_i,
  input  wire logic [7:0] low_thresh_i,
  input  wire logic [7:0] high_thresh_i,
  input  wire logic       low_en_i,
  input  wire logic       high_en_i,
  output logic            low_hit_o,
  output logic            high_hit_o
);

  // Only the upper byte matters in both formats; enables gate the result
  always_comb
  begin
    high_hit_o = high_en_i && (high_byte_i >= high_thresh_i);
    low_hit_o  = low_en_i && (high_byte_i <= low_thresh_i);
  end

endmodule // ltac_alarm_cmp

// file: design/ltac_top.sv
// Logger sensor, alarm, oscillator and mission-setup register bank
// Function
// - Latest result split over two bytes
// - Result code: C = high/2 - 41 (+low/512)
// - Low threshold, then high threshold address
// - Alarms compare upper result byte only
// - Alarm needs alarming value and enable
// - Sensor control bits 7:2 read zero
// - High enable: flag when result >= threshold
// - Low enable: flag when result <= threshold
// - Flags shown in alarm status register
// - Oscillator enable bit runs/stops oscillator
// - Mission start forces oscillator enable
// - Unit select: 0 minutes, 1 seconds
// - Extra start-up delay from cleared memory
// - Oscillator control bits 7:2 read zero
// - Mission bits 7,6,4 read one
// - Mission selects format and overwrite; no overwrite bit here, bit 4 reads one
// - Mission bit postpones logging until alarm
// - Control registers read-only during mission
// - Format bit: 0 eight, 1 sixteen
// - Alarm start: 8-bit, uncounted first sample
// - Logging enable needed; log at base
`timescale 1ns/1ps

module ltac_top
#(
  parameter int OSC_STARTUP_CYCLES = ltac_pkg::OSC_STARTUP_CYCLES
)
(
  input  wire logic        CLOCK_I,
  input  wire logic        NRST_I,
  input  wire logic [9:0]  REG_ADDR_I,
  input  wire logic        REG_WR_I,
  input  wire logic [7:0]  REG_WDATA_I,
  input  wire logic        CONV_VALID_I,
  input  wire logic [10:0] CONV_RESULT_I,
  input  wire logic        MISSION_ACTIVE_I,
  input  wire logic        BEGIN_MISSION_I,
  input  wire logic        CLEAR_MEMORY_I,
  input  wire logic        MEM_CLEARED_I,
  output logic [7:0]       REG_RDATA_O,
  output logic             OSC_ENABLE_O,
  output logic             OSC_READY_O,
  output logic             SECONDS_UNIT_O,
  output logic             LOG_FORMAT_O,
  output logic             CONV_8BIT_O,
  output logic             START_ON_ALARM_O,
  output logic             LOGGING_ENABLE_O,
  output logic             LOG_ACTIVE_O,
  output logic             LOG_SAMPLE_O,
  output logic             HIGH_ALARM_FLAG_O,
  output logic             LOW_ALARM_FLAG_O
);

  // ****************************************
  // Parameter checks
  // ****************************************
  if (OSC_STARTUP_CYCLES < 1 || OSC_STARTUP_CYCLES > 65535)
  begin : g_bad_startup
    $error("OSC_STARTUP_CYCLES must lie in 1..65535");
  end

  localparam logic [15:0] STARTUP_LAST = 16'(OSC_STARTUP_CYCLES - 1);

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0]  low_thresh_q, low_thresh_d;
  logic [7:0]  high_thresh_q, high_thresh_d;
  logic [10:0] result_q, result_d;
  logic [7:0]  sensor_q, sensor_d;
  logic [7:0]  osc_q, osc_d;
  logic [7:0]  mission_q, mission_d;
  logic        high_flag_q, high_flag_d;
  logic        low_flag_q, low_flag_d;
  logic        log_active_q, log_active_d;
  logic        log_sample_q, log_sample_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        low_hit;
  logic        high_hit;
  logic        wr_ok;

  logic        conv_8bit_q, conv_8bit_d;

  ltac_pkg::ltac_osc_state_type osc_state_q, osc_state_d;
  logic [15:0] startup_cnt_q, startup_cnt_d;

  // ****************************************
  // Alarm comparison
  // ****************************************
  ltac_alarm_cmp u_cmp
  (
    .high_byte_i   (CONV_RESULT_I[10:3]),
    .low_thresh_i  (low_thresh_q),
    .high_thresh_i (high_thresh_q),
    .low_en_i      (sensor_q[ltac_pkg::BIT_LOW_ALARM_EN]),
    .high_en_i     (sensor_q[ltac_pkg::BIT_HIGH_ALARM_EN]),
    .low_hit_o     (low_hit),
    .high_hit_o    (high_hit)
  );

  // ****************************************
  // Register writes and sticky flags
  // ****************************************
  // Writes are refused while a mission runs so setup cannot shift under the logger
  assign wr_ok = REG_WR_I && !MISSION_ACTIVE_I;

  always_comb
  begin
    low_thresh_d  = low_thresh_q;
    high_thresh_d = high_thresh_q;
    result_d      = result_q;
    sensor_d      = sensor_q;
    osc_d         = osc_q;
    mission_d     = mission_q;
    if (wr_ok)
    begin
      case (REG_ADDR_I)
        ltac_pkg::ADDR_LOW_THRESH:  low_thresh_d  = REG_WDATA_I;
        ltac_pkg::ADDR_HIGH_THRESH: high_thresh_d = REG_WDATA_I;
        ltac_pkg::ADDR_SENSOR_CTRL: sensor_d  = REG_WDATA_I & ltac_pkg::SENSOR_WR_MASK;
        ltac_pkg::ADDR_OSC_CTRL:    osc_d     = REG_WDATA_I & ltac_pkg::OSC_WR_MASK;
        ltac_pkg::ADDR_MISSION:     mission_d = REG_WDATA_I & ltac_pkg::MISSION_WR_MASK;
        default:                    ;
      endcase
    end
    // Start command wins over a same-cycle write so the clock always runs
    if (BEGIN_MISSION_I)
    begin
      osc_d[ltac_pkg::BIT_OSC_EN] = 1'b1;
    end
    // Latch every conversion, including forced ones outside a mission
    if (CONV_VALID_I)
    begin
      result_d = CONV_RESULT_I;
    end
  end

  // Flags: set wins over clear; only in-mission conversions may raise them
  always_comb
  begin
    high_flag_d  = high_flag_q;
    low_flag_d   = low_flag_q;
    log_active_d = log_active_q;
    log_sample_d = 1'b0;
    if (CLEAR_MEMORY_I)
    begin
      high_flag_d  = 1'b0;
      low_flag_d   = 1'b0;
      log_active_d = 1'b0;
    end
    if (!MISSION_ACTIVE_I)
    begin
      log_active_d = 1'b0;
    end
    else if (CONV_VALID_I)
    begin
      // Both comparisons are checked on every in-mission conversion
      if (high_hit)
      begin
        high_flag_d = 1'b1;
      end
      if (low_hit)
      begin
        low_flag_d = 1'b1;
      end
      if (mission_q[ltac_pkg::BIT_LOGGING_EN])
      begin
        if (!mission_q[ltac_pkg::BIT_START_ON_ALARM] || log_active_q)
        begin
          log_active_d = 1'b1;
          log_sample_d = 1'b1;
        end
        else if (high_hit || low_hit)
        begin
          // Trigger sample is logged; the sample counter is left to skip it
          log_active_d = 1'b1;
          log_sample_d = 1'b1;
        end
      end
    end
    // Taken from next values so the pin is a flop yet moves with the setup it reflects
    conv_8bit_d = !mission_d[ltac_pkg::BIT_LOG_FORMAT]
                  || (mission_d[ltac_pkg::BIT_START_ON_ALARM] && !log_active_d);
  end

  // ****************************************
  // Oscillator start-up
  // ****************************************
  // A start from cleared memory waits the extra delay; otherwise it is usable at once
  always_comb
  begin
    osc_state_d   = osc_state_q;
    startup_cnt_d = startup_cnt_q;
    case (osc_state_q)
      ltac_pkg::OSC_OFF:
      begin
        startup_cnt_d = '0;
        if (osc_q[ltac_pkg::BIT_OSC_EN])
        begin
          osc_state_d = MEM_CLEARED_I ? ltac_pkg::OSC_START : ltac_pkg::OSC_RUN;
        end
      end
      ltac_pkg::OSC_START:
      begin
        startup_cnt_d = startup_cnt_q + 16'h0001;
        if (!osc_q[ltac_pkg::BIT_OSC_EN])
        begin
          osc_state_d = ltac_pkg::OSC_OFF;
        end
        else if (startup_cnt_q == STARTUP_LAST)
        begin
          osc_state_d = ltac_pkg::OSC_RUN;
        end
      end
      ltac_pkg::OSC_RUN:
      begin
        if (!osc_q[ltac_pkg::BIT_OSC_EN])
        begin
          osc_state_d = ltac_pkg::OSC_OFF;
        end
      end
      default:
      begin
        osc_state_d   = ltac_pkg::OSC_OFF;
        startup_cnt_d = '0;
      end
    endcase
  end

  // ****************************************
  // Read data
  // ****************************************
  // Read answer is registered: data appears one edge after the address
  always_comb
  begin
    case (REG_ADDR_I)
      ltac_pkg::ADDR_LOW_THRESH:  rdata_d = low_thresh_q;
      ltac_pkg::ADDR_HIGH_THRESH: rdata_d = high_thresh_q;
      ltac_pkg::ADDR_RESULT_LOW:  rdata_d = {result_q[2:0], 5'b0_0000};
      ltac_pkg::ADDR_RESULT_HIGH: rdata_d = result_q[10:3];
      ltac_pkg::ADDR_SENSOR_CTRL: rdata_d = sensor_q & ltac_pkg::SENSOR_WR_MASK;
      ltac_pkg::ADDR_OSC_CTRL:    rdata_d = osc_q & ltac_pkg::OSC_WR_MASK;
      ltac_pkg::ADDR_MISSION:     rdata_d = mission_q | ltac_pkg::MISSION_ONES;
      ltac_pkg::ADDR_ALARM_STAT:
        rdata_d = ltac_pkg::ALARM_STAT_ONES | {6'b00_0000, high_flag_q, low_flag_q};
      default:                    rdata_d = 8'h00;
    endcase
  end

  // ****************************************
  // Flip-flops
  // ****************************************
  always_ff @(posedge CLOCK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      low_thresh_q  <= ltac_pkg::RESET_BYTE;
      high_thresh_q <= ltac_pkg::RESET_BYTE;
      result_q      <= ltac_pkg::RESET_RESULT;
      sensor_q      <= ltac_pkg::RESET_BYTE;
      osc_q         <= ltac_pkg::RESET_BYTE;
      mission_q     <= ltac_pkg::RESET_BYTE;
      high_flag_q   <= 1'b0;
      low_flag_q    <= 1'b0;
      log_active_q  <= 1'b0;
      log_sample_q  <= 1'b0;
      conv_8bit_q   <= 1'b1; // Format bit resets to 0, which means 8-bit
      rdata_q       <= ltac_pkg::RESET_BYTE;
      osc_state_q   <= ltac_pkg::OSC_OFF;
      startup_cnt_q <= 16'h0000;
    end
    else
    begin
      low_thresh_q  <= low_thresh_d;
      high_thresh_q <= high_thresh_d;
      result_q      <= result_d;
      sensor_q      <= sensor_d;
      osc_q         <= osc_d;
      mission_q     <= mission_d;
      high_flag_q   <= high_flag_d;
      low_flag_q    <= low_flag_d;
      log_active_q  <= log_active_d;
      log_sample_q  <= log_sample_d;
      conv_8bit_q   <= conv_8bit_d;
      rdata_q       <= rdata_d;
      osc_state_q   <= osc_state_d;
      startup_cnt_q <= startup_cnt_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Bit 1 of mission setup is stored but drives nothing; host must keep it zero
  always_comb
  begin
    REG_RDATA_O       = rdata_q;
    OSC_ENABLE_O      = osc_q[ltac_pkg::BIT_OSC_EN];
    OSC_READY_O       = osc_state_q[2];
    SECONDS_UNIT_O    = osc_q[ltac_pkg::BIT_SECONDS_UNIT];
    LOG_FORMAT_O      = mission_q[ltac_pkg::BIT_LOG_FORMAT];
    CONV_8BIT_O       = conv_8bit_q;
    START_ON_ALARM_O  = mission_q[ltac_pkg::BIT_START_ON_ALARM];
    LOGGING_ENABLE_O  = mission_q[ltac_pkg::BIT_LOGGING_EN];
    LOG_ACTIVE_O      = log_active_q;
    LOG_SAMPLE_O      = log_sample_q;
    HIGH_ALARM_FLAG_O = high_flag_q;
    LOW_ALARM_FLAG_O  = low_flag_q;
  end

endmodule // ltac_top

// file: sim/ltac_host.sv
// Host model: register reads and writes on the bank's register port
`timescale 1ns/1ps

module ltac_host
(
  input  wire logic [7:0] rdata_i,
  input  wire logic       clk_i,
  output logic [9:0]      addr_o,
  output logic            wr_o,
  output logic [7:0]      wdata_o
);
  // ****
  // Bus tasks
  // ****
  initial
  begin
    addr_o = 10'h000;
    wr_o = 1'b0;
    wdata_o = 8'h00;
  end

  // One-cycle strobe; data turned round once the strobe drops
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_i) #1;
    addr_o = a;
    wr_o = 1'b1;
    wdata_o = (a == ltac_pkg::ADDR_MISSION) ? (d & 8'hFD) : d;
    @(posedge clk_i) #1;
    wr_o = 1'b0;
    wdata_o = ~wdata_o;
  endtask

  // Data is taken one edge after the address
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk_i) #1;
    addr_o = a;
    @(posedge clk_i) #1;
    d = rdata_i;
  endtask

  // Threshold code from half-degree steps, so resolution is 0.5 C
  function automatic logic [7:0] code(input int half_deg);
    return 8'(half_deg + ltac_pkg::THRESH_OFFSET);
  endfunction
endmodule // ltac_host

// file: sim/ltac_top_asserts.sv
// Checker: port-level properties of the alarm/config bank
`timescale 1ns/1ps

module ltac_top_asserts
#(
  parameter int OSC_STARTUP_CYCLES = ltac_pkg::OSC_STARTUP_CYCLES
)
(
  input wire logic       CLOCK_I,
  input wire logic       NRST_I,
  input wire logic [9:0] REG_ADDR_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic       CONV_VALID_I,
  input wire logic       MISSION_ACTIVE_I,
  input wire logic       BEGIN_MISSION_I,
  input wire logic       CLEAR_MEMORY_I,
  input wire logic       MEM_CLEARED_I,
  input wire logic       OSC_ENABLE_O,
  input wire logic       OSC_READY_O,
  input wire logic       SECONDS_UNIT_O,
  input wire logic       LOG_FORMAT_O,
  input wire logic       START_ON_ALARM_O,
  input wire logic       LOGGING_ENABLE_O,
  input wire logic       HIGH_ALARM_FLAG_O,
  input wire logic       LOW_ALARM_FLAG_O
);
  // ****
  // Properties
  // ****
  // Slack of a few cycles over the start-up count for state hops
  localparam int RDY_MAX = OSC_STARTUP_CYCLES + 4;
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!NRST_I);

  sensor_pad_zero_a : assert property (
    REG_ADDR_I == ltac_pkg::ADDR_SENSOR_CTRL |=> REG_RDATA_O[7:2] == 6'h00)
    else $error("sensor control upper bits not zero");
  osc_pad_zero_a : assert property (
    REG_ADDR_I == ltac_pkg::ADDR_OSC_CTRL |=> REG_RDATA_O[7:2] == 6'h00)
    else $error("oscillator control upper bits not zero");
  mission_ones_a : assert property (
    REG_ADDR_I == ltac_pkg::ADDR_MISSION |=> REG_RDATA_O[7:6] == 2'b11 && REG_RDATA_O[4])
    else $error("mission fixed ones missing");
  result_low_pad_a : assert property (
    REG_ADDR_I == ltac_pkg::ADDR_RESULT_LOW |=> REG_RDATA_O[4:0] == 5'h00)
    else $error("result low byte padding not zero");
  high_flag_cause_a : assert property (
    $rose(HIGH_ALARM_FLAG_O) |-> $past(CONV_VALID_I) && $past(MISSION_ACTIVE_I))
    else $error("high flag rose without mission conversion");
  low_flag_cause_a : assert property (
    $rose(LOW_ALARM_FLAG_O) |-> $past(CONV_VALID_I) && $past(MISSION_ACTIVE_I))
    else $error("low flag rose without mission conversion");
  flags_sticky_a : assert property (
    !CLEAR_MEMORY_I |=> HIGH_ALARM_FLAG_O >= $past(HIGH_ALARM_FLAG_O)
      && LOW_ALARM_FLAG_O >= $past(LOW_ALARM_FLAG_O))
    else $error("alarm flag dropped without clear");
  begin_sets_osc_a : assert property (
    BEGIN_MISSION_I |=> OSC_ENABLE_O)
    else $error("mission start did not enable oscillator");
  osc_off_ready_a : assert property (
    !OSC_ENABLE_O ##1 !OSC_ENABLE_O |-> !OSC_READY_O)
    else $error("oscillator ready while disabled");
  cold_start_wait_a : assert property (
    $rose(OSC_ENABLE_O) && MEM_CLEARED_I |-> !OSC_READY_O [*3] ##[1:RDY_MAX] OSC_READY_O)
    else $error("cold oscillator start delay wrong");
  mission_lock_a : assert property (
    MISSION_ACTIVE_I |=> $stable({SECONDS_UNIT_O, LOG_FORMAT_O,
      START_ON_ALARM_O, LOGGING_ENABLE_O}))
    else $error("control changed during mission");
endmodule // ltac_top_asserts

bind ltac_top ltac_top_asserts #(.OSC_STARTUP_CYCLES(OSC_STARTUP_CYCLES)) u_chk
(
  .CLOCK_I, .NRST_I, .REG_ADDR_I, .REG_RDATA_O, .CONV_VALID_I, .MISSION_ACTIVE_I,
  .BEGIN_MISSION_I, .CLEAR_MEMORY_I, .MEM_CLEARED_I, .OSC_ENABLE_O, .OSC_READY_O,
  .SECONDS_UNIT_O, .LOG_FORMAT_O, .START_ON_ALARM_O, .LOGGING_ENABLE_O,
  .HIGH_ALARM_FLAG_O, .LOW_ALARM_FLAG_O
);

// file: sim/ltac_top_tb.sv
// Testbench: registers, alarms, oscillator and mission lock of the bank
`timescale 1ns/1ps

module ltac_top_tb;
  logic        CLOCK_I, NRST_I, REG_WR_I, CONV_VALID_I, MISSION_ACTIVE_I;
  logic        BEGIN_MISSION_I, CLEAR_MEMORY_I, MEM_CLEARED_I;
  logic [9:0]  REG_ADDR_I;
  logic [7:0]  REG_WDATA_I, REG_RDATA_O, d;
  logic [10:0] CONV_RESULT_I;
  logic        OSC_ENABLE_O, OSC_READY_O, SECONDS_UNIT_O, LOG_FORMAT_O, CONV_8BIT_O;
  logic        START_ON_ALARM_O, LOGGING_ENABLE_O, LOG_ACTIVE_O, LOG_SAMPLE_O;
  logic        HIGH_ALARM_FLAG_O, LOW_ALARM_FLAG_O;
  int          fails, samples_checked, n;
  // Address, written value (FF for read-only ones) and expected read-back
  logic [9:0]  ra [9] = '{10'h208, 10'h209, 10'h20A, 10'h20C, 10'h20D,
                          10'h210, 10'h212, 10'h213, 10'h214};
  logic [7:0]  rz [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hD0, 8'h70};
  logic [9:0]  wa [8] = '{10'h210, 10'h212, 10'h213, 10'h20D, 10'h214,
                          10'h208, 10'h209, 10'h213};
  logic [7:0]  wd [8] = '{8'hFF, 8'hFE, 8'h00, 8'hFF, 8'hFF, 8'h3E, 8'h85, 8'h27};
  logic [7:0]  we [8] = '{8'h03, 8'h02, 8'hD0, 8'h00, 8'h70, 8'h3E, 8'h85, 8'hF5};
  logic [10:0] cr [3] = '{{8'h60, 3'b0}, {8'h85, 3'b111}, {8'h3E, 3'b0}};
  logic [4:0]  ce [3] = '{5'b1_0000, 5'b0_1110, 5'b0_1111};

  ltac_top #(.OSC_STARTUP_CYCLES(4)) DUT
  (
    .CLOCK_I, .NRST_I, .REG_ADDR_I, .REG_WR_I, .REG_WDATA_I, .CONV_VALID_I,
    .CONV_RESULT_I, .MISSION_ACTIVE_I, .BEGIN_MISSION_I, .CLEAR_MEMORY_I,
    .MEM_CLEARED_I, .REG_RDATA_O, .OSC_ENABLE_O, .OSC_READY_O, .SECONDS_UNIT_O,
    .LOG_FORMAT_O, .CONV_8BIT_O, .START_ON_ALARM_O, .LOGGING_ENABLE_O,
    .LOG_ACTIVE_O, .LOG_SAMPLE_O, .HIGH_ALARM_FLAG_O, .LOW_ALARM_FLAG_O
  );
  ltac_host host
  (
    .rdata_i(REG_RDATA_O), .clk_i(CLOCK_I), .addr_o(REG_ADDR_I),
    .wr_o(REG_WR_I), .wdata_o(REG_WDATA_I)
  );

  // ****
  // Helpers
  // ****
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic beat;
    @(posedge CLOCK_I) #1;
  endtask
  // Result lines turned round once the strobe drops
  task automatic conv(input logic [10:0] r);
    beat();
    CONV_VALID_I = 1'b1;
    CONV_RESULT_I = r;
    beat();
    CONV_VALID_I = 1'b0;
    CONV_RESULT_I = ~r;
  endtask
  // Expected: 8-bit conversion, log active, log sample, high flag, low flag
  task automatic flags(input logic [4:0] e);
    chk({3'h0, CONV_8BIT_O, LOG_ACTIVE_O, LOG_SAMPLE_O, HIGH_ALARM_FLAG_O, LOW_ALARM_FLAG_O},
        {3'h0, e});
  endtask
  task automatic close_out;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    CLOCK_I = 1'b0;
    forever #5 CLOCK_I = ~CLOCK_I;
  end

  // ****
  // Main sequence
  // ****
  initial
  begin
    {NRST_I, CONV_VALID_I, MISSION_ACTIVE_I, BEGIN_MISSION_I} = 4'h0;
    {CLEAR_MEMORY_I, MEM_CLEARED_I} = 2'b00;
    CONV_RESULT_I = 11'h000;
    fails = 0;
    samples_checked = 0;
    repeat (3) @(posedge CLOCK_I);
    #1 NRST_I = 1'b1;
    foreach (ra[i]) begin host.rd(ra[i], d); chk(d, rz[i]); end
    $display("test reset_values done");
    foreach (wa[i]) begin host.wr(wa[i], wd[i]); host.rd(wa[i], d); chk(d, we[i]); end
    chk(host.code(-20), 8'h3E);
    chk({3'h0, SECONDS_UNIT_O, LOG_FORMAT_O, START_ON_ALARM_O, LOGGING_ENABLE_O, CONV_8BIT_O},
        8'h1F);
    $display("test write_masks done");
    conv({8'h90, 3'b101});
    host.rd(10'h20D, d); chk(d, 8'h90);
    host.rd(10'h20C, d); chk(d, 8'hA0);
    flags(5'b1_0000);
    $display("test result_bytes done");
    MEM_CLEARED_I = 1'b1;
    beat();
    BEGIN_MISSION_I = 1'b1;
    beat();
    BEGIN_MISSION_I = 1'b0;
    chk({7'h0, OSC_ENABLE_O}, 8'h01);
    for (n = 0; n < 20 && OSC_READY_O !== 1'b1; n++) beat();
    if (n == 20) begin fails++; close_out(); end
    chk(8'(n), 8'h05);
    MISSION_ACTIVE_I = 1'b1;
    foreach (cr[i]) begin conv(cr[i]); flags(ce[i]); end
    host.wr(10'h210, 8'h00);
    host.wr(10'h208, 8'hFF);
    host.wr(10'h212, 8'h00);
    host.rd(10'h210, d); chk(d, 8'h03);
    host.rd(10'h208, d); chk(d, 8'h3E);
    host.rd(10'h212, d); chk(d, 8'h03);
    $display("test mission_alarms done");
    MISSION_ACTIVE_I = 1'b0;
    conv(11'h000);
    flags(5'b1_0011);
    beat();
    CLEAR_MEMORY_I = 1'b1;
    beat();
    CLEAR_MEMORY_I = 1'b0;
    flags(5'b1_0000);
    host.wr(10'h210, 8'h02);
    host.wr(10'h213, 8'h05);
    MISSION_ACTIVE_I = 1'b1;
    conv(11'h000);
    flags(5'b0_1100);
    MISSION_ACTIVE_I = 1'b0;
    host.wr(10'h212, 8'h00);
    beat();
    chk({6'h0, OSC_ENABLE_O, OSC_READY_O}, 8'h00);
    $display("test clear_and_stop done");
    close_out();
  end
endmodule // ltac_top_tb
